// [peripheral_dma_channel_regs.svh]
// register offsets, field positions and reset values of the dma channel
`ifndef PERIPHERAL_DMA_CHANNEL_REGS_SVH
`define PERIPHERAL_DMA_CHANNEL_REGS_SVH

`define RX_CUR_PTR_OFS 8'h00
`define RX_CUR_CNT_OFS 8'h04
`define TX_CUR_PTR_OFS 8'h08
`define TX_CUR_CNT_OFS 8'h0c
`define RX_NXT_PTR_OFS 8'h10
`define RX_NXT_CNT_OFS 8'h14
`define TX_NXT_PTR_OFS 8'h18
`define TX_NXT_CNT_OFS 8'h1c
`define CTRL_OFS       8'h20
`define STATUS_OFS     8'h24
`define SIZE_CFG_OFS   8'h28

`define RX_EN_BIT      0
`define RX_DIS_BIT     1
`define TX_EN_BIT      8
`define TX_DIS_BIT     9
`define RX_STAT_BIT    0
`define TX_STAT_BIT    8

`define PTR_RST        32'h0000_0000
`define CNT_RST        16'h0000
`define SIZE_RST       2'h2

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [dma_types_pkg.sv]
// types shared by the dma channel modules
package dma_types_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RX_HOLD = 3'b001,
    ST_RX_MEM  = 3'b010,
    ST_TX_MEM  = 3'b011,
    ST_TX_HOLD = 3'b100
  } xfer_state_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } item_size_t;

endpackage : dma_types_pkg

// [axil_slave_port.sv]
// axi4-lite slave front end: one write and one read in flight
`include "peripheral_dma_channel_regs.svh"
module axil_slave_port (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  output logic        wr_req,
  output logic [7:0]  wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0]  wr_strb,
  input  logic        wr_ok,
  input  logic [31:0] rd_data,
  input  logic        rd_ok
);
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q;
  logic arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic aw_take, w_take, rd_take;
  logic aw_got_d, w_got_d, bvalid_d, rvalid_d;

  assign aw_take  = awvalid & awready_q;
  assign w_take   = wvalid & wready_q;
  assign rd_take  = arvalid & arready_q;
  // address and data may arrive in either order
  assign wr_req   = aw_got_q & w_got_q & ~bvalid_q;
  assign aw_got_d = wr_req ? 1'b0 : (aw_got_q | aw_take);
  assign w_got_d  = wr_req ? 1'b0 : (w_got_q | w_take);
  assign bvalid_d = wr_req | (bvalid_q & ~bready);
  assign rvalid_d = rd_take | (rvalid_q & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q  <= ~w_got_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (wr_req) begin
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        wr_addr <= awaddr;
      end
      if (w_take) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (rd_take) begin
        rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
        rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
endmodule : axil_slave_port

// [chan_pair.sv]
// current and next pointer/counter pair with reload and end flags
`include "peripheral_dma_channel_regs.svh"
module chan_pair (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [31:0] wdata,
  input  logic        wr_cur_ptr,
  input  logic        wr_cur_cnt,
  input  logic        wr_nxt_ptr,
  input  logic        wr_nxt_cnt,
  input  logic        step,
  input  logic [2:0]  step_bytes,
  output logic [31:0] cur_ptr,
  output logic [15:0] cur_cnt,
  output logic [31:0] nxt_ptr,
  output logic [15:0] nxt_cnt,
  output logic        end_flag,
  output logic        buf_flag
);
  logic last, reload, clr;

  assign last   = step & (cur_cnt == 16'h0001);
  assign reload = last & (nxt_cnt != 16'h0000);
  assign clr    = (wr_cur_cnt | wr_nxt_cnt) & (wdata[15:0] != 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ptr <= `PTR_RST;
      nxt_ptr <= `PTR_RST;
    end else begin
      if (wr_cur_ptr) cur_ptr <= wdata;
      else if (reload) cur_ptr <= nxt_ptr;
      else if (step) cur_ptr <= cur_ptr + {29'h0, step_bytes};
      if (wr_nxt_ptr) nxt_ptr <= wdata;
      else if (reload) nxt_ptr <= `PTR_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_cnt <= `CNT_RST;
      nxt_cnt <= `CNT_RST;
    end else begin
      if (wr_cur_cnt) cur_cnt <= wdata[15:0];
      else if (reload) cur_cnt <= nxt_cnt;
      else if (step) cur_cnt <= cur_cnt - 16'h0001;
      if (wr_nxt_cnt) nxt_cnt <= wdata[15:0];
      else if (reload) nxt_cnt <= `CNT_RST;
    end
  end

  // set wins over a same-cycle clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_flag <= 1'b0;
      buf_flag <= 1'b0;
    end else begin
      if (last) end_flag <= 1'b1;
      else if (clr) end_flag <= 1'b0;
      if (last && !reload) buf_flag <= 1'b1;
      else if (clr) buf_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ptr_advance_a: assert property (step && !wr_cur_ptr && !reload
    |=> cur_ptr == $past(cur_ptr) + {29'h0, $past(step_bytes)})
    else $error("pointer did not advance by item size");
  cnt_reload_a: assert property (reload && !wr_cur_cnt && !wr_nxt_cnt
    |=> cur_cnt == $past(nxt_cnt) && nxt_cnt == 16'h0000)
    else $error("next pair not moved into current pair");
  buf_set_a: assert property (last && nxt_cnt == 16'h0000 && !wr_cur_cnt
    |=> buf_flag && end_flag && cur_cnt == 16'h0000)
    else $error("buffer flag or stop missing at final item");
endmodule : chan_pair

// [peripheral_dma_channel.sv]
// peripheral dma channel: registers, transfer sequencer, bus ports
// Contract
// - one-direction channel holds current and next 32-bit pointer, 16-bit counter.
// - two-direction channel holds four pointers and four counters.
// - remaining counts are readable at any moment, also mid-transfer.
// - separate enable/disable commands per direction; status shows enabled state.
// - pointer advances 1, 2 or 4 bytes per byte, half-word, word item.
// - pointer rewritten mid-transfer is used for following accesses.
// - current counter decrements per item; next consulted only at zero.
// - both counters zero stops movement and raises completion flag.
// - next nonzero reloads current pair, clears next pair, continues.
// - receive-ready leads to holding register read, buffering, memory write.
// - transmit-ready leads to memory fetch, then holding register write.
// - receive end flag set at zero; nonzero receive count write clears.
// - transmit end flag set at zero; nonzero transmit count write clears.
// - receive full flag set when both receive counters zero.
// - transmit empty flag set when both transmit counters zero.
// - completion is signalled by the peripheral; no interrupt line here.
// - flags reach software only through the peripheral status register.
// - half-duplex shares one channel's flags; full-duplex has two channels.
// - zero count halts a direction; 1 to 65535 runs it if enabled.
// - half-duplex receive and transmit names share one storage.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`include "peripheral_dma_channel_regs.svh"

module peripheral_dma_channel #(
  parameter int HALF_DUPLEX = 0
) (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  input  logic        rx_ready_strobe,
  input  logic        tx_ready_strobe,
  input  logic [31:0] rx_holding_register,
  output logic        rx_hold_read,
  output logic [31:0] tx_holding_register,
  output logic        tx_hold_write,
  output logic        mem_req,
  output logic        mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0]  mem_size,
  input  logic        mem_gnt,
  input  logic [31:0] mem_rdata,
  output logic        rx_end_flag,
  output logic        tx_end_flag,
  output logic        rx_buffer_full_flag,
  output logic        tx_buffer_empty_flag,
  output logic        rx_enabled,
  output logic        tx_enabled
);
  // half duplex maps the transmit names onto engine 0
  localparam int TX_E = (HALF_DUPLEX != 0) ? 0 : 1;

  if (HALF_DUPLEX != 0 && HALF_DUPLEX != 1) begin : g_bad_mode
    $error("HALF_DUPLEX must be 0 or 1");
  end

  logic [31:0] cur_ptr [2];
  logic [15:0] cur_cnt [2];
  logic [31:0] nxt_ptr [2];
  logic [15:0] nxt_cnt [2];
  logic        end_f   [2];
  logic        buf_f   [2];

  logic        wr_req;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] wmask;
  logic [32:0] wr_view;
  logic [32:0] rd_view;
  logic [31:0] merged;
  logic [31:0] ctrl_w;
  logic        ctrl_wr;

  dma_types_pkg::xfer_state_t st_q;
  logic [1:0]  size_q;
  logic [2:0]  step_bytes;
  logic        rx_en_q, tx_en_q;
  logic        rx_pend_q, tx_pend_q;
  logic        rx_go, tx_go;
  logic        rx_step, tx_step;
  logic        rx_hold_read_q, tx_hold_write_q;
  logic        mem_req_q, mem_write_q;
  logic [31:0] mem_addr_q, mem_wdata_q, tx_hold_q;
  logic [1:0]  mem_size_q;

  // counts are plain registers, so a read mid-transfer is exact
  function automatic logic [32:0] reg_view(input logic [7:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    if (a == `RX_CUR_PTR_OFS) v[31:0] = cur_ptr[0];
    else if (a == `RX_CUR_CNT_OFS) v[15:0] = cur_cnt[0];
    else if (a == `TX_CUR_PTR_OFS) v[31:0] = cur_ptr[TX_E];
    else if (a == `TX_CUR_CNT_OFS) v[15:0] = cur_cnt[TX_E];
    else if (a == `RX_NXT_PTR_OFS) v[31:0] = nxt_ptr[0];
    else if (a == `RX_NXT_CNT_OFS) v[15:0] = nxt_cnt[0];
    else if (a == `TX_NXT_PTR_OFS) v[31:0] = nxt_ptr[TX_E];
    else if (a == `TX_NXT_CNT_OFS) v[15:0] = nxt_cnt[TX_E];
    else if (a == `CTRL_OFS) v[31:0] = 32'h0000_0000;
    else if (a == `STATUS_OFS) begin
      v[`RX_STAT_BIT] = rx_en_q;
      v[`TX_STAT_BIT] = tx_en_q;
    end
    else if (a == `SIZE_CFG_OFS) v[1:0] = size_q;
    else v[32] = 1'b0;
    return v;
  endfunction : reg_view

  axil_slave_port u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_view[32]),
    .rd_data (rd_view[31:0]),
    .rd_ok   (rd_view[32])
  );

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{wr_strb[b]}};
  end

  always_comb begin
    wr_view = reg_view(wr_addr);
    rd_view = reg_view(araddr);
  end

  assign merged  = (wr_view[31:0] & ~wmask) | (wr_data & wmask);
  assign ctrl_w  = wr_data & wmask;
  assign ctrl_wr = wr_req && wr_addr == `CTRL_OFS;

  for (genvar e = 0; e < 2; e++) begin : g_dir
    logic is_rx, is_tx;
    logic wcp, wcc, wnp, wnc, stp;
    assign is_rx = (e == 0);
    assign is_tx = (e == TX_E);
    // half duplex: both names land in one pair
    assign wcp = wr_req && ((is_rx && wr_addr == `RX_CUR_PTR_OFS)
                 || (is_tx && wr_addr == `TX_CUR_PTR_OFS));
    assign wcc = wr_req && ((is_rx && wr_addr == `RX_CUR_CNT_OFS)
                 || (is_tx && wr_addr == `TX_CUR_CNT_OFS));
    assign wnp = wr_req && ((is_rx && wr_addr == `RX_NXT_PTR_OFS)
                 || (is_tx && wr_addr == `TX_NXT_PTR_OFS));
    assign wnc = wr_req && ((is_rx && wr_addr == `RX_NXT_CNT_OFS)
                 || (is_tx && wr_addr == `TX_NXT_CNT_OFS));
    assign stp = (is_rx && rx_step) || (is_tx && tx_step);

    chan_pair u_pair (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .wdata      (merged),
      .wr_cur_ptr (wcp),
      .wr_cur_cnt (wcc),
      .wr_nxt_ptr (wnp),
      .wr_nxt_cnt (wnc),
      .step       (stp),
      .step_bytes (step_bytes),
      .cur_ptr    (cur_ptr[e]),
      .cur_cnt    (cur_cnt[e]),
      .nxt_ptr    (nxt_ptr[e]),
      .nxt_cnt    (nxt_cnt[e]),
      .end_flag   (end_f[e]),
      .buf_flag   (buf_f[e])
    );
  end

  // one-shot commands, disable dominates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      if (ctrl_w[`RX_DIS_BIT]) rx_en_q <= 1'b0;
      else if (ctrl_w[`RX_EN_BIT]) rx_en_q <= 1'b1;
      if (ctrl_w[`TX_DIS_BIT]) tx_en_q <= 1'b0;
      else if (ctrl_w[`TX_EN_BIT]) tx_en_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) size_q <= `SIZE_RST;
    else if (wr_req && wr_addr == `SIZE_CFG_OFS) size_q <= merged[1:0];
  end

  // unused code 3 falls back to word steps
  always_comb begin
    case (size_q)
      dma_types_pkg::SZ_BYTE: step_bytes = 3'h1;
      dma_types_pkg::SZ_HALF: step_bytes = 3'h2;
      default:                step_bytes = 3'h4;
    endcase
  end

  // strobes wait here until served; a new strobe wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_pend_q <= 1'b0;
      tx_pend_q <= 1'b0;
    end else begin
      rx_pend_q <= rx_ready_strobe | (rx_pend_q & ~rx_go);
      tx_pend_q <= tx_ready_strobe | (tx_pend_q & ~tx_go);
    end
  end

  // zero count holds a direction still; receive served first
  assign rx_go = st_q == dma_types_pkg::ST_IDLE && rx_pend_q && rx_en_q
                 && cur_cnt[0] != 16'h0000;
  assign tx_go = st_q == dma_types_pkg::ST_IDLE && !rx_go && tx_pend_q
                 && tx_en_q && cur_cnt[TX_E] != 16'h0000;
  assign rx_step = st_q == dma_types_pkg::ST_RX_MEM && mem_gnt;
  assign tx_step = st_q == dma_types_pkg::ST_TX_HOLD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= dma_types_pkg::ST_IDLE;
    end else begin
      case (st_q)
        dma_types_pkg::ST_IDLE: begin
          if (rx_go) st_q <= dma_types_pkg::ST_RX_HOLD;
          else if (tx_go) st_q <= dma_types_pkg::ST_TX_MEM;
        end
        dma_types_pkg::ST_RX_HOLD: st_q <= dma_types_pkg::ST_RX_MEM;
        dma_types_pkg::ST_RX_MEM: begin
          if (mem_gnt) st_q <= dma_types_pkg::ST_IDLE;
        end
        dma_types_pkg::ST_TX_MEM: begin
          if (mem_gnt) st_q <= dma_types_pkg::ST_TX_HOLD;
        end
        default: st_q <= dma_types_pkg::ST_IDLE;
      endcase
    end
  end

  // holding register side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_read_q  <= 1'b0;
      tx_hold_write_q <= 1'b0;
      tx_hold_q       <= 32'h0000_0000;
    end else begin
      rx_hold_read_q  <= rx_go;
      tx_hold_write_q <= st_q == dma_types_pkg::ST_TX_MEM && mem_gnt;
      if (st_q == dma_types_pkg::ST_TX_MEM && mem_gnt) begin
        tx_hold_q <= mem_rdata;
      end
    end
  end

  // memory side; the address is the pointer at issue time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req_q   <= 1'b0;
      mem_write_q <= 1'b0;
      mem_addr_q  <= `PTR_RST;
      mem_wdata_q <= 32'h0000_0000;
      mem_size_q  <= `SIZE_RST;
    end else begin
      if (st_q == dma_types_pkg::ST_RX_HOLD) begin
        mem_req_q   <= 1'b1;
        mem_write_q <= 1'b1;
        mem_addr_q  <= cur_ptr[0];
        mem_wdata_q <= rx_holding_register;
        mem_size_q  <= size_q;
      end else if (tx_go) begin
        mem_req_q   <= 1'b1;
        mem_write_q <= 1'b0;
        mem_addr_q  <= cur_ptr[TX_E];
        mem_size_q  <= size_q;
      end else if (mem_gnt) begin
        mem_req_q <= 1'b0;
      end
    end
  end

  assign rx_hold_read         = rx_hold_read_q;
  assign tx_hold_write        = tx_hold_write_q;
  assign tx_holding_register  = tx_hold_q;
  assign mem_req              = mem_req_q;
  assign mem_write            = mem_write_q;
  assign mem_addr             = mem_addr_q;
  assign mem_wdata            = mem_wdata_q;
  assign mem_size             = mem_size_q;
  // flags go to the served peripheral's status register only
  assign rx_end_flag          = end_f[0];
  assign tx_end_flag          = end_f[TX_E];
  assign rx_buffer_full_flag  = buf_f[0];
  assign tx_buffer_empty_flag = buf_f[TX_E];
  assign rx_enabled           = rx_en_q;
  assign tx_enabled           = tx_en_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rx_sequence_a: assert property (rx_hold_read_q |=> mem_req_q
    && mem_write_q && mem_wdata_q == $past(rx_holding_register))
    else $error("receive item not buffered and written");
  tx_sequence_a: assert property (tx_hold_write_q
    |-> $past(mem_req_q) && !$past(mem_write_q) && $past(mem_gnt)
    && tx_hold_q == $past(mem_rdata))
    else $error("transmit item not fetched before hold write");
  zero_halt_a: assert property (st_q == dma_types_pkg::ST_IDLE
    && cur_cnt[0] == 16'h0000 && cur_cnt[TX_E] == 16'h0000
    |=> !mem_req_q && !rx_hold_read_q)
    else $error("movement started with zero count");
  en_dis_both_a: assert property (ctrl_wr && ctrl_w[`RX_EN_BIT]
    && ctrl_w[`RX_DIS_BIT] |=> !rx_en_q)
    else $error("enable with disable left channel on");
  end_flag_set_a: assert property (rx_step && cur_cnt[0] == 16'h0001
    |=> rx_end_flag)
    else $error("receive end flag not raised");
  req_hold_a: assert property (mem_req_q && !mem_gnt
    |=> mem_req_q && $stable(mem_addr_q))
    else $error("memory request dropped before grant");
  half_share_a: assert property (HALF_DUPLEX != 0
    |-> tx_end_flag == rx_end_flag)
    else $error("half duplex flags diverged");
endmodule : peripheral_dma_channel

// [dma_far_side_model.sv]
// far side model: memory port of the bus matrix and peripheral holding registers
module dma_far_side_model (
  input  wire logic        aclk,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        rx_hold_read,
  input  wire logic        tx_hold_write,
  input  wire logic [31:0] tx_holding_register,
  input  wire logic [3:0]  gnt_delay,
  output logic             mem_gnt,
  output logic [31:0]      mem_rdata,
  output logic [31:0]      rx_holding_register
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  wait_q = 4'h0;
  logic [31:0] junk_q = 32'h5555_aaaa;
  logic [31:0] last_addr;
  logic [31:0] last_wdata;
  int          writes = 0;
  int          sends = 0;
  initial mem_gnt = 1'b0;
  initial rx_holding_register = 32'ha000_0000;
  // data only valid in the grant cycle, a changing pattern otherwise
  assign mem_rdata = mem_gnt ? (mem_addr ^ 32'hc3c3_0000) : junk_q;
  always @(posedge aclk) begin
    junk_q <= ~junk_q;
    mem_gnt <= 1'b0;
    if (mem_req && !mem_gnt) begin
      wait_q <= (wait_q == gnt_delay) ? 4'h0 : wait_q + 4'h1;
      mem_gnt <= (wait_q == gnt_delay);
    end
    if (mem_req && mem_gnt && mem_write) begin
      last_addr <= mem_addr;
      last_wdata <= mem_wdata;
      writes <= writes + 1;
    end
    if (rx_hold_read) rx_holding_register <= rx_holding_register + 32'h1;
    if (tx_hold_write) sends <= sends + 1;
  end
endmodule : dma_far_side_model

// [peripheral_dma_channel_tb_top.sv]
// self-checking bench for the peripheral dma channel
`include "peripheral_dma_channel_regs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module peripheral_dma_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, rx_ready_strobe, tx_ready_strobe, rx_hold_read;
  logic        tx_hold_write, mem_req, mem_write, mem_gnt, rx_enabled, tx_enabled;
  logic        rx_end_flag, tx_end_flag, rx_buffer_full_flag, tx_buffer_empty_flag;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb, gnt_delay;
  logic [1:0]  bresp, rresp, mem_size;
  logic [31:0] wdata, rdata, rx_holding_register, tx_holding_register;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rx_seq;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  peripheral_dma_channel #(.HALF_DUPLEX(0)) peripheral_dma_channel_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rx_ready_strobe, .tx_ready_strobe, .rx_holding_register, .rx_hold_read,
    .tx_holding_register, .tx_hold_write, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .mem_size, .mem_gnt, .mem_rdata, .rx_end_flag, .tx_end_flag, .rx_buffer_full_flag,
    .tx_buffer_empty_flag, .rx_enabled, .tx_enabled);
  dma_far_side_model dma_far_side_model_i (
    .aclk, .mem_req, .mem_write, .mem_addr, .mem_wdata, .rx_hold_read, .tx_hold_write,
    .tx_holding_register, .gnt_delay, .mem_gnt, .mem_rdata, .rx_holding_register);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_of_test();
    end
  end

  // readies are sampled mid-cycle, they only move on rising edges
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 40) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = tb ? bresp : 2'h1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, got;
    int   n;
    n = 0;
    got = 1'b0;
    r = 2'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 40) begin
      @(negedge aclk);
      ta = arvalid && arready;
      got = rvalid;
      if (got) d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
      n++;
    end
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    `CHK("write response", `RESP_OKAY, r)
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    `CHK(nm, e, d)
  endtask : rd_chk

  // a lost item shows only by waiting
  task automatic kick(input logic tx, input int moves);
    int n0, n;
    n0 = tx ? dma_far_side_model_i.sends : dma_far_side_model_i.writes;
    n = 0;
    @(posedge aclk);
    if (tx) tx_ready_strobe <= 1'b1;
    else rx_ready_strobe <= 1'b1;
    @(posedge aclk);
    tx_ready_strobe <= 1'b0;
    rx_ready_strobe <= 1'b0;
    while ((tx ? dma_far_side_model_i.sends : dma_far_side_model_i.writes) - n0 < moves
           && n < 30) begin
      @(posedge aclk);
      n++;
    end
    repeat (moves == 0 ? 12 : 3) @(posedge aclk);
    `CHK("items moved", moves, (tx ? dma_far_side_model_i.sends : dma_far_side_model_i.writes) - n0)
  endtask : kick

  task automatic rx_item(input logic [31:0] a, input logic [31:0] m);
    kick(1'b0, 1);
    `CHK("rx address", a, dma_far_side_model_i.last_addr)
    `CHK("rx data", rx_seq & m, dma_far_side_model_i.last_wdata & m)
    `CHK("rx size", 2'h0, mem_size)
    rx_seq = rx_seq + 32'h1;
  endtask : rx_item

  task automatic tx_item(input logic [31:0] a);
    kick(1'b1, 1);
    `CHK("tx data", a ^ 32'hc3c3_0000, tx_holding_register)
  endtask : tx_item

  task automatic t_reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    for (int a = 0; a < 40; a += 4) rd_chk("reset value", a[7:0], 32'h0);
    rd_chk("size reset", `SIZE_CFG_OFS, {30'h0, `SIZE_RST});
    axr(8'h2c, d, r);
    `CHK("unmapped read", `RESP_SLVERR, r)
    axw(8'h30, 32'h1, r);
    `CHK("unmapped write", `RESP_SLVERR, r)
    wr(`RX_CUR_CNT_OFS, 32'hdead_0007);
    rd_chk("count width", `RX_CUR_CNT_OFS, 32'h7);
  endtask : t_reset_values

  task automatic t_rx();
    wr(`SIZE_CFG_OFS, 32'h0);
    wr(`RX_CUR_PTR_OFS, 32'h100);
    wr(`RX_CUR_CNT_OFS, 32'h2);
    wr(`RX_NXT_PTR_OFS, 32'h200);
    wr(`RX_NXT_CNT_OFS, 32'h1);
    wr(`CTRL_OFS, 32'h1);
    rd_chk("rx status", `STATUS_OFS, 32'h1);
    rx_item(32'h100, 32'hff);
    rd_chk("rx count mid", `RX_CUR_CNT_OFS, 32'h1);
    rx_item(32'h101, 32'hff);
    `CHK("rx end at reload", 1'b1, rx_end_flag)
    `CHK("rx full held", 1'b0, rx_buffer_full_flag)
    rd_chk("next count zero", `RX_NXT_CNT_OFS, 32'h0);
    rd_chk("reload count", `RX_CUR_CNT_OFS, 32'h1);
    rx_item(32'h200, 32'hff);
    `CHK("rx full", 1'b1, rx_buffer_full_flag)
    kick(1'b0, 0);
    wr(`CTRL_OFS, 32'h3);
    rd_chk("both commands", `STATUS_OFS, 32'h0);
    wr(`RX_CUR_CNT_OFS, 32'h1);
    `CHK("rx end clear", 1'b0, rx_end_flag)
    `CHK("rx full clear", 1'b0, rx_buffer_full_flag)
    kick(1'b0, 0);
    wr(`CTRL_OFS, 32'h1);
    rx_item(32'h201, 32'hff);
  endtask : t_rx

  task automatic t_tx();
    wr(`SIZE_CFG_OFS, 32'h1);
    wr(`TX_CUR_PTR_OFS, 32'h300);
    wr(`TX_CUR_CNT_OFS, 32'h3);
    wr(`CTRL_OFS, 32'h100);
    rd_chk("tx status", `STATUS_OFS, 32'h101);
    `CHK("enables", 2'h3, {rx_enabled, tx_enabled})
    tx_item(32'h300);
    rd_chk("half step", `TX_CUR_PTR_OFS, 32'h302);
    wr(`TX_CUR_PTR_OFS, 32'h400);
    wr(`SIZE_CFG_OFS, 32'h2);
    tx_item(32'h400);
    rd_chk("word step", `TX_CUR_PTR_OFS, 32'h404);
    tx_item(32'h404);
    `CHK("tx end", 1'b1, tx_end_flag)
    `CHK("tx empty", 1'b1, tx_buffer_empty_flag)
    wr(`TX_CUR_CNT_OFS, 32'h1);
    `CHK("tx end clear", 1'b0, tx_end_flag)
    `CHK("tx empty clear", 1'b0, tx_buffer_empty_flag)
    `CHK("rx flag apart", 1'b1, rx_end_flag)
    wr(`CTRL_OFS, 32'h200);
    rd_chk("tx disabled", `STATUS_OFS, 32'h1);
  endtask : t_tx

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rx_ready_strobe, tx_ready_strobe} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    gnt_delay = 4'h0;
    rx_seq = 32'ha000_0000;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_rx();
    gnt_delay <= 4'h3;
    t_tx();
    end_of_test();
  end
endmodule : peripheral_dma_channel_tb_top
